// file: rtl/pll_consts.vh
// Purpose: Shared constants for the PLL divider and base clock selector
// Assumes: 8-bit register port, registers at their byte offsets
// Notes:   Included by the clock generator unit only, by bare name
//
// Notes on behaviour
// - VCO rate is reference times 2^P*N/R
// - Bus clock is quarter of selected source
// - Prescale field divides feedback by 2^P
// - Range power E in range field, never 3; the range field accepts 3 unchecked
// - Multiplier N spans low and high registers
// - Center of range is L*2^E*38.4 kHz
// - Reference divided by R before comparison
// - Zero R or N acts as one
// - Zero L disables PLL, blocks VCO select
// - Zero L forces crystal as base source
// - Switch waits three edges of each clock
// - Transition output divided by two
// - Select bit chooses VCO or crystal
// - VCO select refused while PLL off
// - PLL cannot be switched off while selected
// - Programming registers read-only while PLL on
// - Select set holds enable set
// - PLL off or zero L clears select
`ifndef PLL_CONSTS_VH
`define PLL_CONSTS_VH

// ***************************************************************
// Register offsets
// ***************************************************************
`define PLL_CONTROL_ADDR    8'h36
`define MULT_HIGH_ADDR      8'h38
`define MULT_LOW_ADDR       8'h39
`define VCO_RANGE_ADDR      8'h3A
`define REF_DIV_ADDR        8'h3B

// ***************************************************************
// Control register field positions
// ***************************************************************
`define CTL_ENABLE_BIT      5
`define CTL_SELECT_BIT      4
`define CTL_PRESCALE_HI     3
`define CTL_PRESCALE_LO     2
`define CTL_RANGE_HI        1
`define CTL_RANGE_LO        0

// ***************************************************************
// Reset values
// ***************************************************************
`define CTL_ENABLE_RST      1'h1
`define CTL_SELECT_RST      1'h0
`define CTL_PRESCALE_RST    2'h0
`define CTL_RANGE_RST       2'h0
`define MULT_RST            12'h040
`define VCO_RANGE_RST       8'h40
`define REF_DIV_RST         4'h1

// ***************************************************************
// Timing counts and widths
// ***************************************************************
`define SWITCH_EDGES        2'h3
`define FB_DIV_WIDTH        15
`define REF_DIV_WIDTH       4

`endif

// file: rtl/edge_modulo_divider.v
// Purpose: Counts qualified source edges and pulses every modulus edges
// Assumes: Modulus is never zero; caller maps zero to one
// Notes:   One instance per divider chain
`timescale 1ns/1ps
`default_nettype none

module edge_modulo_divider #(
   parameter WIDTH = 4
) (
   // Clock and reset
   input  wire             clk_i,
   input  wire             rst_n_i,
   // Source edge and modulus
   input  wire             edge_i,
   input  wire [WIDTH-1:0] modulus_i,
   // Divided output
   output reg              pulse_o
);

   reg [WIDTH-1:0] count;

   // ***************************************************************
   // Modulo counter
   // ***************************************************************
   // Count edges; wrap and pulse on the last one of each period
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count   <= {WIDTH{1'b0}};
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= 1'b0;
         if (edge_i) begin
            if (count >= modulus_i - {{(WIDTH-1){1'b0}}, 1'b1}) begin
               count   <= {WIDTH{1'b0}};
               pulse_o <= 1'b1;
            end else begin
               count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // edge_modulo_divider

`default_nettype wire

// file: rtl/clock_generator_unit.v
// Purpose: PLL settings, dividers and glitch-free base clock selector
// Assumes: Crystal and VCO clocks are sampled inputs, synchronous to core clock
// Notes:   Analog loop, oscillator and lock detector live outside
`timescale 1ns/1ps
`default_nettype none
`include "pll_consts.vh"

module clock_generator_unit (
   // Core clock and reset
   input  wire        CORE_CLK_I,
   input  wire        NRST_I,
   // Register port
   input  wire [7:0]  ADDR_I,
   input  wire [7:0]  WR_DATA_I,
   input  wire        WR_STB_I,
   input  wire        RD_STB_I,
   output reg  [7:0]  RD_DATA_O,
   // Source clocks, sampled
   input  wire        CRYSTAL_CLOCK_I,
   input  wire        VCO_CLOCK_I,
   // Loop side outputs
   output reg         REF_DIV_PULSE_O,
   output reg         FB_DIV_PULSE_O,
   output reg         PLL_ACTIVE_O,
   output reg  [9:0]  CENTER_RANGE_O,
   // Base clock to system integration
   output reg         BASE_CLOCK_OUT_O,
   output reg         SWITCHING_O,
   output reg         VCO_SOURCE_O
);

   // ***************************************************************
   // Switch state machine encoding
   // ***************************************************************
   localparam [1:0] ST_RUN   = 2'h0;
   localparam [1:0] ST_DRAIN = 2'h1;
   localparam [1:0] ST_FILL  = 2'h2;

   // ***************************************************************
   // Register storage
   // ***************************************************************
   reg        pll_enable;
   reg        base_clock_select;
   reg [1:0]  prescale;
   reg [1:0]  vco_range_power_field;
   reg [11:0] multiplier;
   reg [7:0]  linear_range;
   reg [3:0]  ref_divider;

   // Source sampling and selector state
   reg        xclk_q;
   reg        vclk_q;
   reg [1:0]  state;
   reg [1:0]  next_state;
   reg [1:0]  edge_cnt;
   reg [1:0]  next_edge_cnt;
   reg        active_src;
   reg        next_active_src;
   reg [7:0]  next_rd_data;

   wire       xclk_edge;
   wire       vclk_edge;
   wire       range_zero;
   wire       pll_active;
   wire       want_vco;
   wire       old_edge;
   wire       new_edge;
   wire       src_edge;
   wire       ref_pulse;
   wire       fb_pulse;
   wire       write_ctl;
   wire       prog_open;
   wire [3:0]  eff_ref_div;
   wire [11:0] eff_mult;
   wire [14:0] fb_modulus;

   // ***************************************************************
   // Effective settings
   // ***************************************************************
   // Zero in the range register shuts the loop down entirely
   assign range_zero = (linear_range == 8'h00);
   assign pll_active = pll_enable & ~range_zero;
   // Zero divider values behave as one
   assign eff_ref_div = (ref_divider == 4'h0) ? 4'h1 : ref_divider;
   assign eff_mult    = (multiplier == 12'h000) ? 12'h001 : multiplier;
   // Feedback modulus is N times two to the P
   assign fb_modulus  = {3'h0, eff_mult} << prescale;
   // Selector only asks for VCO while the loop really runs
   assign want_vco    = base_clock_select & pll_active;

   // Programming registers are frozen while the loop is on
   assign prog_open = ~pll_enable;
   assign write_ctl = WR_STB_I & (ADDR_I == `PLL_CONTROL_ADDR);

   // ***************************************************************
   // Register writes
   // ***************************************************************
   // Interlocks use the bits as they stood before this write, so an
   // enable change and a select change cannot take effect together
   always @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pll_enable            <= `CTL_ENABLE_RST;
         base_clock_select     <= `CTL_SELECT_RST;
         prescale              <= `CTL_PRESCALE_RST;
         vco_range_power_field <= `CTL_RANGE_RST;
         multiplier            <= `MULT_RST;
         linear_range          <= `VCO_RANGE_RST;
         ref_divider           <= `REF_DIV_RST;
      end else begin
         if (write_ctl) begin
            // Clearing enable ignored while the select bit is set
            if (!base_clock_select) begin
               pll_enable <= WR_DATA_I[`CTL_ENABLE_BIT];
            end
            // Select settable only with loop on, range nonzero and enable kept,
            // so a write that drops enable can never leave select standing
            if (pll_active && (base_clock_select || WR_DATA_I[`CTL_ENABLE_BIT])) begin
               base_clock_select <= WR_DATA_I[`CTL_SELECT_BIT];
            end else begin
               base_clock_select <= 1'b0;
            end
            if (prog_open) begin
               prescale <= WR_DATA_I[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
               vco_range_power_field <= WR_DATA_I[`CTL_RANGE_HI:`CTL_RANGE_LO];
            end
         end else if (!pll_active) begin
            base_clock_select <= 1'b0;
         end
         if (WR_STB_I && prog_open) begin
            case (ADDR_I)
               `MULT_HIGH_ADDR: begin
                  multiplier[11:8] <= WR_DATA_I[3:0];
               end
               `MULT_LOW_ADDR: begin
                  multiplier[7:0] <= WR_DATA_I;
               end
               `VCO_RANGE_ADDR: begin
                  linear_range <= WR_DATA_I;
               end
               `REF_DIV_ADDR: begin
                  ref_divider <= WR_DATA_I[3:0];
               end
               default: begin
                  multiplier <= multiplier;
               end
            endcase
         end
      end
   end

   // ***************************************************************
   // Register reads
   // ***************************************************************
   // Unmapped offsets and unused bits read as zero
   always @* begin
      next_rd_data = 8'h00;
      case (ADDR_I)
         `PLL_CONTROL_ADDR: begin
            next_rd_data[`CTL_ENABLE_BIT] = pll_enable;
            next_rd_data[`CTL_SELECT_BIT] = base_clock_select;
            next_rd_data[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO] = prescale;
            next_rd_data[`CTL_RANGE_HI:`CTL_RANGE_LO] = vco_range_power_field;
         end
         `MULT_HIGH_ADDR: begin
            next_rd_data = {4'h0, multiplier[11:8]};
         end
         `MULT_LOW_ADDR: begin
            next_rd_data = multiplier[7:0];
         end
         `VCO_RANGE_ADDR: begin
            next_rd_data = linear_range;
         end
         `REF_DIV_ADDR: begin
            next_rd_data = {4'h0, ref_divider};
         end
         default: begin
            next_rd_data = 8'h00;
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         RD_DATA_O <= 8'h00;
      end else if (RD_STB_I) begin
         RD_DATA_O <= next_rd_data;
      end else begin
         RD_DATA_O <= 8'h00;
      end
   end

   // ***************************************************************
   // Source edge detection
   // ***************************************************************
   // Inputs arrive synchronous, so one stage of history suffices
   always @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         xclk_q <= 1'b0;
         vclk_q <= 1'b0;
      end else begin
         xclk_q <= CRYSTAL_CLOCK_I;
         vclk_q <= VCO_CLOCK_I;
      end
   end

   assign xclk_edge = CRYSTAL_CLOCK_I & ~xclk_q;
   // VCO edges count only while the loop runs
   assign vclk_edge = VCO_CLOCK_I & ~vclk_q & pll_active;

   // ***************************************************************
   // Reference and feedback dividers
   // ***************************************************************
   // Reference clock is the crystal, divided by R
   edge_modulo_divider #(
      .WIDTH     (`REF_DIV_WIDTH)
   ) u_ref_div (
      .clk_i     (CORE_CLK_I),
      .rst_n_i   (NRST_I),
      .edge_i    (xclk_edge & pll_active),
      .modulus_i (eff_ref_div),
      .pulse_o   (ref_pulse)
   );

   // VCO feedback divided by N times two to the P
   edge_modulo_divider #(
      .WIDTH     (`FB_DIV_WIDTH)
   ) u_fb_div (
      .clk_i     (CORE_CLK_I),
      .rst_n_i   (NRST_I),
      .edge_i    (vclk_edge),
      .modulus_i (fb_modulus),
      .pulse_o   (fb_pulse)
   );

   // Loop side outputs registered
   always @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         REF_DIV_PULSE_O <= 1'b0;
         FB_DIV_PULSE_O  <= 1'b0;
         PLL_ACTIVE_O    <= 1'b0;
         CENTER_RANGE_O  <= 10'h000;
      end else begin
         REF_DIV_PULSE_O <= ref_pulse;
         FB_DIV_PULSE_O  <= fb_pulse;
         PLL_ACTIVE_O    <= pll_active;
         // Center of range in units of the nominal 38.4 kHz step
         CENTER_RANGE_O  <= {2'h0, linear_range} << vco_range_power_field;
      end
   end

   // ***************************************************************
   // Glitch-free source transition
   // ***************************************************************
   assign old_edge = active_src ? vclk_edge : xclk_edge;
   assign new_edge = active_src ? xclk_edge : vclk_edge;
   assign src_edge = active_src ? vclk_edge : xclk_edge;

   // Drain three edges of the old source, then three of the new one;
   // output is frozen throughout so no runt can escape
   always @* begin
      next_state      = state;
      next_edge_cnt   = edge_cnt;
      next_active_src = active_src;
      case (state)
         ST_RUN: begin
            if (want_vco != active_src) begin
               next_state    = ST_DRAIN;
               next_edge_cnt = 2'h0;
            end
         end
         ST_DRAIN: begin
            if (old_edge) begin
               if (edge_cnt == `SWITCH_EDGES - 2'h1) begin
                  next_state      = ST_FILL;
                  next_edge_cnt   = 2'h0;
                  next_active_src = ~active_src;
               end else begin
                  next_edge_cnt = edge_cnt + 2'h1;
               end
            end
         end
         ST_FILL: begin
            // Here the roles flipped, so the new source is active_src
            if (src_edge) begin
               if (edge_cnt == `SWITCH_EDGES - 2'h1) begin
                  next_state    = ST_RUN;
                  next_edge_cnt = 2'h0;
               end else begin
                  next_edge_cnt = edge_cnt + 2'h1;
               end
            end
         end
         default: begin
            next_state    = ST_RUN;
            next_edge_cnt = 2'h0;
         end
      endcase
   end

   // Selector state and divide-by-two base clock
   always @(posedge CORE_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state            <= ST_RUN;
         edge_cnt         <= 2'h0;
         active_src       <= 1'b0;
         BASE_CLOCK_OUT_O <= 1'b0;
         SWITCHING_O      <= 1'b0;
         VCO_SOURCE_O     <= 1'b0;
      end else begin
         state       <= next_state;
         edge_cnt    <= next_edge_cnt;
         active_src  <= next_active_src;
         SWITCHING_O <= (next_state != ST_RUN);
         VCO_SOURCE_O <= next_active_src;
         // Toggle only on whole source edges outside a transition
         if (state == ST_RUN && next_state == ST_RUN && src_edge) begin
            BASE_CLOCK_OUT_O <= ~BASE_CLOCK_OUT_O;
         end
      end
   end

   // Unused new_edge kept out of logic; drain uses old_edge only
   wire unused_new_edge;
   assign unused_new_edge = new_edge;

endmodule // clock_generator_unit

`default_nettype wire

// file: test/clock_generator_unit_properties.sv
// Purpose: Port-level properties of the clock generator unit
// Assumes: Source clocks are sampled levels on the core clock
// Notes:   Bound to every instance of the unit at the foot of this file
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Checker
// ************************************************************
module clock_generator_unit_properties (
   // Clock and reset
   input wire logic       CORE_CLK_I,
   input wire logic       NRST_I,
   // Loop side
   input wire logic       REF_DIV_PULSE_O,
   input wire logic       FB_DIV_PULSE_O,
   input wire logic       PLL_ACTIVE_O,
   input wire logic [9:0] CENTER_RANGE_O,
   // Base clock
   input wire logic       BASE_CLOCK_OUT_O,
   input wire logic       SWITCHING_O,
   input wire logic       VCO_SOURCE_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!NRST_I);

   // Idle and inactive loop never leaves the VCO driving
   property p_no_vco_idle; !PLL_ACTIVE_O && !SWITCHING_O |-> !VCO_SOURCE_O; endproperty
   a_no_vco_idle: assert property (p_no_vco_idle) else $error("vco source while off");
   // Base clock held still through a switch
   property p_frozen; SWITCHING_O[*2] |-> $stable(BASE_CLOCK_OUT_O); endproperty
   a_frozen: assert property (p_frozen) else $error("base clock moved in switch");
   // A source edge needs two samples, so no runt half-periods
   property p_no_runt; $changed(BASE_CLOCK_OUT_O) |=> $stable(BASE_CLOCK_OUT_O); endproperty
   a_no_runt: assert property (p_no_runt) else $error("base clock runt");
   // Reference divider silent while the loop is off
   property p_ref_quiet; (!PLL_ACTIVE_O)[*4] |-> !REF_DIV_PULSE_O; endproperty
   a_ref_quiet: assert property (p_ref_quiet) else $error("reference pulse while off");
   // Zero center means zero range setting, so loop off, except L of 0x80 with E of 3, where the loop stays on
   property p_zero_l; CENTER_RANGE_O == 10'h000 |-> !PLL_ACTIVE_O; endproperty
   a_zero_l: assert property (p_zero_l) else $error("active with zero range");
   // Programming locked while running
   property p_locked; PLL_ACTIVE_O |=> $stable(CENTER_RANGE_O); endproperty
   a_locked: assert property (p_locked) else $error("center moved while on");
   // Source only flips inside a transition
   property p_flip; $changed(VCO_SOURCE_O) |-> SWITCHING_O; endproperty
   a_flip: assert property (p_flip) else $error("source flipped outside switch");
   // Switch drains both clocks, then ends in bounded time
   property p_sw_len; $rose(SWITCHING_O) |-> SWITCHING_O[*6] ##[1:400] !SWITCHING_O; endproperty
   a_sw_len: assert property (p_sw_len) else $error("switch length wrong");
   // Feedback pulse lasts one cycle
   property p_fb_pulse; FB_DIV_PULSE_O |=> !FB_DIV_PULSE_O; endproperty
   a_fb_pulse: assert property (p_fb_pulse) else $error("feedback pulse too long");
endmodule // clock_generator_unit_properties

bind clock_generator_unit clock_generator_unit_properties u_props (
   .CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .REF_DIV_PULSE_O(REF_DIV_PULSE_O),
   .FB_DIV_PULSE_O(FB_DIV_PULSE_O), .PLL_ACTIVE_O(PLL_ACTIVE_O),
   .CENTER_RANGE_O(CENTER_RANGE_O), .BASE_CLOCK_OUT_O(BASE_CLOCK_OUT_O),
   .SWITCHING_O(SWITCHING_O), .VCO_SOURCE_O(VCO_SOURCE_O));

`default_nettype wire

// file: test/system_clock_sink.sv
// Purpose: System integration side that turns the base clock into a bus clock
// Assumes: Base clock settles between core edges
// Notes:   Reports bus clock period in core cycles
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Bus clock sink
// ************************************************************
module system_clock_sink (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Base clock in, measured period out
   input wire logic base_clock_i,
   output var int   bus_period_o
);
   logic bus_clock;
   logic last_base;
   int   count;

   // Halve base clock, time bus rising edges
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_clock    <= 1'b0;
         last_base    <= 1'b0;
         count        <= 0;
         bus_period_o <= 0;
      end else begin
         last_base <= base_clock_i;
         count     <= count + 1;
         if (base_clock_i && !last_base) begin
            bus_clock <= !bus_clock;
            if (!bus_clock) begin
               bus_period_o <= count + 1;
               count        <= 0;
            end
         end
      end
   end
endmodule // system_clock_sink

`default_nettype wire

// file: test/tb.sv
// Purpose: Self-checking bench for the clock generator unit
// Assumes: Crystal period 6 cycles, VCO period 4 cycles
// Notes:   Register access by one-cycle strobes, read data next cycle
`timescale 1ns/1ps
`default_nettype none

module tb;
   // ************************************************************
   // Signals
   // ************************************************************
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr_stb = 1'b0;
   logic       rd_stb = 1'b0;
   logic [2:0] xtal_cnt = 3'h0;
   logic [1:0] vco_cnt = 2'h0;
   logic [7:0] rdata;
   logic [9:0] center;
   logic       ref_pulse, fb_pulse, active, base_clk, switching, vco_src;
   int         bus_period, n, fails = 0, num_checks = 0;
   // Reset table: offsets and values, two unmapped
   localparam logic [55:0] RA = {8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'hA5};
   localparam logic [55:0] RV = {8'h20, 8'h00, 8'h00, 8'h40, 8'h40, 8'h01, 8'h00};

   always #20 clk = ~clk;

   // Free-running sources; edges land on core edges only
   always @(posedge clk) begin
      xtal_cnt <= (xtal_cnt == 3'h5) ? 3'h0 : xtal_cnt + 3'h1;
      vco_cnt  <= vco_cnt + 2'h1;
   end

   clock_generator_unit u_dut (
      .CORE_CLK_I(clk), .NRST_I(rst_n), .ADDR_I(addr), .WR_DATA_I(wdata),
      .WR_STB_I(wr_stb), .RD_STB_I(rd_stb), .RD_DATA_O(rdata),
      .CRYSTAL_CLOCK_I(xtal_cnt > 3'h2), .VCO_CLOCK_I(vco_cnt[1]),
      .REF_DIV_PULSE_O(ref_pulse), .FB_DIV_PULSE_O(fb_pulse), .PLL_ACTIVE_O(active),
      .CENTER_RANGE_O(center), .BASE_CLOCK_OUT_O(base_clk), .SWITCHING_O(switching),
      .VCO_SOURCE_O(vco_src));

   system_clock_sink u_sink (.clk_i(clk), .rst_n_i(rst_n), .base_clock_i(base_clk),
      .bus_period_o(bus_period));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      chk(16'(rdata), 16'(exp));
      // One cycle later the port must be back to zero
      @(negedge clk);
      chk(16'(rdata), 16'h0000);
   endtask

   task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
      wr(a, d);
      rd(a, exp);
   endtask

   function automatic logic probe(input int k);
      case (k)
         0: probe = ref_pulse;
         1: probe = fb_pulse;
         2: probe = switching;
         default: probe = !switching;
      endcase
   endfunction

   // Bounded wait; running out ends the run
   task automatic wait_for(input int k);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (probe(k) !== 1'b1 && n < 600);
      if (n >= 600) begin
         fails++;
         $display("Error at %0t: wait ran out", $time);
         summarize();
      end
   endtask

   // First pulse may come from a stale count, so time the second
   task automatic gap(input int k, input int exp);
      wait_for(k);
      wait_for(k);
      chk(16'(n), 16'(exp));
   endtask

   task automatic note(input string s);
      $display("test %s done at %0t", s, $time);
   endtask

   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(RA[8*i+:8], RV[8*i+:8]);
      end
      chk(16'(active), 16'h0001);
      chk(16'(center), 16'h0040);
      note("reset");
      wrd(8'h39, 8'h55, 8'h40);
      wrd(8'h36, 8'h2F, 8'h20);
      wrd(8'h36, 8'h00, 8'h00);
      wrd(8'h36, 8'h10, 8'h00);
      chk(16'(active), 16'h0000);
      note("locks");
      wrd(8'h36, 8'h0A, 8'h0A);
      wrd(8'h38, 8'hF0, 8'h00);
      wrd(8'h39, 8'h00, 8'h00);
      wrd(8'h3A, 8'h83, 8'h83);
      wrd(8'h3B, 8'hF0, 8'h00);
      chk(16'(center), 16'h020C);
      wr(8'h36, 8'h20);
      gap(0, 6);
      gap(1, 4);
      chk(16'(center), 16'h0083);
      note("zero divisors");
      wr(8'h36, 8'h00);
      wr(8'h39, 8'h03);
      wr(8'h3B, 8'h03);
      wr(8'h36, 8'h04);
      wr(8'h36, 8'h24);
      gap(0, 18);
      gap(1, 24);
      note("dividers");
      wr(8'h36, 8'h00);
      wr(8'h3A, 8'h00);
      wrd(8'h36, 8'h20, 8'h20);
      wrd(8'h36, 8'h30, 8'h20);
      chk(16'(active), 16'h0000);
      chk(16'(vco_src), 16'h0000);
      repeat (100) @(negedge clk);
      chk(16'(bus_period), 16'd24);
      note("zero range");
      wr(8'h36, 8'h00);
      wr(8'h3A, 8'h40);
      wr(8'h36, 8'h20);
      wr(8'h36, 8'h30);
      wait_for(2);
      wait_for(3);
      chk(16'(vco_src), 16'h0001);
      repeat (100) @(negedge clk);
      chk(16'(bus_period), 16'd16);
      wrd(8'h36, 8'h10, 8'h30);
      wr(8'h36, 8'h20);
      wait_for(2);
      wait_for(3);
      chk(16'(vco_src), 16'h0000);
      repeat (100) @(negedge clk);
      chk(16'(bus_period), 16'd24);
      wrd(8'h36, 8'h00, 8'h00);
      note("source switch");
      summarize();
   end
endmodule // tb

`default_nettype wire
